// ---- pkg/gmm_defs.svh ----
// Constants for the gauge memory map: offsets, ranges, field positions.
// Assumes the includer uses the offsets as sized constants and the field positions as bit indices.
//
// Overview of operation
// [R1] Decode 256 byte addresses: results, status, control, parameter and user storage.
// [R2] Reserved locations read as undefined; this design returns zero there.
// [R3] The host should never write reserved byte locations.
// [R4] Sixteen-bit values sit MSB at even address, LSB at next odd address.
// [R5] Reading a high byte captures both bytes; low byte held until command ends.
// [R6] Host reads high and low byte within one read-data command.
// [R7] Host reads and writes of storage blocks touch only the shadow copy.
// [R8] Copy moves shadow to nonvolatile cells; recall loads cells into shadow.
// [R9] Host writes shadow then copies; host recalls then reads to verify.
// [R10] Sixteen-byte user block at 20h-2Fh affects no other function.
// [R11] A locked user block refuses writes but still allows reads.
// [R12] Parameter block lives at 60h-7Fh and can be locked.
// [R13] Crossing a 4% capacity boundary saves coulomb count and age scalar.
// [R14] Backup only during active operation; restored from cells at power-up.
// [R15] Measurement and capacity locations are read-only to the host.
// [R16] Status, special feature, storage control, coulomb count, age scalar are writable.
// [R17] Factory voltage and sense trims are read-only pairs at AEh and B0h.
// [R18] While a copy runs, host writes to storage-backed addresses are ignored.
// [R19] Locking is permanent; nothing unlocks a block. Here reset clears the lock bits.
// [R20] Writes to read-only locations are discarded.
// [R21] A bus reset ends the read command and releases the high-byte capture.
`ifndef GMM_DEFS_SVH
`define GMM_DEFS_SVH
`define GMM_A_STATUS      8'h01
`define GMM_A_ABS_ACT     8'h02
`define GMM_A_ABS_STBY    8'h04
`define GMM_A_REL_ACT     8'h06
`define GMM_A_REL_STBY    8'h07
`define GMM_A_AVG_CUR     8'h08
`define GMM_A_TEMP        8'h0a
`define GMM_A_VOLTAGE_RESULT        8'h0c
`define GMM_A_CURR        8'h0e
`define GMM_A_COULOMB     8'h10
`define GMM_A_LOW_COUL    8'h12
`define GMM_A_AGE         8'h14
`define GMM_A_SPECIAL     8'h15
`define GMM_A_FULL        8'h16
`define GMM_A_ACT_EMPTY   8'h18
`define GMM_A_STBY_EMPTY  8'h1a
`define GMM_A_NV_CTRL     8'h1f
`define GMM_USER_LO       8'h20
`define GMM_USER_HI       8'h2f
`define GMM_PARAM_LO      8'h60
`define GMM_PARAM_HI      8'h7f
`define GMM_A_FV_TRIM     8'hae
`define GMM_A_FS_TRIM     8'hb0
`define GMM_BIT_COPY      7
`define GMM_BIT_LOCK_EN   6
`define GMM_BIT_LOCK1     1
`define GMM_BIT_LOCK0     0
`define GMM_STEP_PCT      8'h04
`define GMM_RST_STATUS    8'h00
`define GMM_RST_SPECIAL   8'h01
`define GMM_STORE_LEN     9'h030
`define GMM_NV_COUL_IDX   6'h30
`define GMM_NV_AGE_IDX    6'h32
`define GMM_NV_LEN        6'h33
`endif

// ---- pkg/gmm_pkg.sv ----
// Types for the gauge memory map.
// Assumes gmm_defs.svh supplies the numeric constants.
package gmm_pkg;
    typedef enum logic [2:0] {GMM_CMD_NONE, GMM_CMD_COPY, GMM_CMD_RECALL,
                              GMM_CMD_LOCK, GMM_CMD_END} gmm_cmd_t;
    typedef enum {GMM_IDLE, GMM_COPYING, GMM_RESTORE} gmm_state_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gmm_req_t;
    typedef struct packed {
        logic [15:0] abs_act;
        logic [15:0] abs_stby;
        logic [7:0]  rel_act;
        logic [7:0]  rel_stby;
        logic [15:0] avg_cur;
        logic [15:0] temp;
        logic [15:0] voltage_result;
        logic [15:0] curr;
        logic [15:0] low_coul;
        logic [15:0] full;
        logic [15:0] act_empty;
        logic [15:0] stby_empty;
        logic [15:0] fv_trim;
        logic [15:0] fs_trim;
    } gmm_meas_t;
endpackage

// ---- verilog/gmm_map.sv ----
// Register map of the gauge: decode, shadow storage, copy/recall, locks, backup.
// Assumes the serial front end delivers byte requests and command pulses on mclk,
// and the measurement engine supplies results and coulomb/age updates.
`timescale 1ns/1ps
`default_nettype none
`include "gmm_defs.svh"
module gmm_map
    import gmm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire gmm_req_t    req,
    input  wire gmm_cmd_t    cmd,
    input  wire logic        active_mode,
    input  wire gmm_meas_t   meas,
    input  wire logic        coul_upd,
    input  wire logic [15:0] coul_upd_val,
    input  wire logic        age_upd,
    input  wire logic [7:0]  age_upd_val,
    output logic [7:0]       rdata_r,
    output logic             rvalid_r,
    output logic [7:0]       status_r,
    output logic [7:0]       special_r,
    output logic [15:0]      coulomb_r,
    output logic [7:0]       age_r,
    output logic [7:0]       nv_ctrl_r,
    output logic             busy_r
);
    // Shadow and cell images: 48 bytes of storage plus 3 backup bytes in the cells.
    logic [7:0]  shadow_r [0:47];
    logic [7:0]  cells_r  [0:50];
    logic [7:0]  hold_lo_r;
    logic [7:0]  last_pct_r;
    logic [5:0]  xfer_r;
    logic        backup_r;
    gmm_state_t  state_r;
    gmm_state_t  state_nxt;

    // Address classes.
    wire [7:0] a         = req.addr;
    wire       in_user   = (a >= `GMM_USER_LO) && (a <= `GMM_USER_HI); // R10
    wire       in_param  = (a >= `GMM_PARAM_LO) && (a <= `GMM_PARAM_HI); // R12
    wire       in_store  = in_user || in_param;
    wire [5:0] sidx      = in_user ? 6'(a - `GMM_USER_LO) : 6'(a - `GMM_PARAM_LO + 8'h10);
    wire       lock0     = nv_ctrl_r[`GMM_BIT_LOCK0];
    wire       lock1     = nv_ctrl_r[`GMM_BIT_LOCK1];
    wire       copying   = nv_ctrl_r[`GMM_BIT_COPY];
    // Storage writes pass only when unlocked and no copy runs.
    wire       store_wr  = req.wr && in_store && !copying && !busy_r // R18
                           && !(in_user && lock0) && !(in_param && lock1); // R11 R19
    wire       coul_hw   = req.wr && (a == `GMM_A_COULOMB);
    wire       coul_lw   = req.wr && (a == `GMM_A_COULOMB + 8'h01);
    wire       age_w     = req.wr && (a == `GMM_A_AGE);
    // A crossing of any 4% step in relative capacity while active_mode is high and the sequencer is idle arms a backup.
    wire [7:0] step_now  = meas.rel_act / `GMM_STEP_PCT;
    wire [7:0] step_last = last_pct_r / `GMM_STEP_PCT;
    wire       pct_cross = active_mode && (state_r == GMM_IDLE) && (step_now != step_last); // R13 R14

    // Pick the value for any pair address; even picks MSB, odd picks LSB.
    function automatic logic [7:0] pick(input logic [15:0] v, input logic odd);
        pick = odd ? v[7:0] : v[15:8]; // R4
    endfunction

    // Even address of the pair that holds the addressed byte.
    wire [7:0] pa = {a[7:1], 1'b0};

    // Full read decode before any low-byte hold is applied.
    logic [15:0] pair_v;
    logic        is_pair;
    logic [7:0]  raw_rd;
    always_comb
    begin
        pair_v  = 16'h0000;
        is_pair = 1'b1;
        if (pa == `GMM_A_ABS_ACT) pair_v = meas.abs_act;
        else if (pa == `GMM_A_ABS_STBY) pair_v = meas.abs_stby;
        else if (pa == `GMM_A_AVG_CUR) pair_v = meas.avg_cur;
        else if (pa == `GMM_A_TEMP) pair_v = meas.temp;
        else if (pa == `GMM_A_VOLTAGE_RESULT) pair_v = meas.voltage_result;
        else if (pa == `GMM_A_CURR) pair_v = meas.curr;
        else if (pa == `GMM_A_COULOMB) pair_v = coulomb_r;
        else if (pa == `GMM_A_LOW_COUL) pair_v = meas.low_coul;
        else if (pa == `GMM_A_FULL) pair_v = meas.full;
        else if (pa == `GMM_A_ACT_EMPTY) pair_v = meas.act_empty;
        else if (pa == `GMM_A_STBY_EMPTY) pair_v = meas.stby_empty;
        else if (pa == `GMM_A_FV_TRIM) pair_v = meas.fv_trim; // R17
        else if (pa == `GMM_A_FS_TRIM) pair_v = meas.fs_trim; // R17
        else is_pair = 1'b0;
        // Reserved addresses return zero, which is one legal undefined value.
        raw_rd = 8'h00; // R2
        if (is_pair) raw_rd = pick(pair_v, a[0]); // R1
        else if (a == `GMM_A_STATUS) raw_rd = status_r;
        else if (a == `GMM_A_REL_ACT) raw_rd = meas.rel_act;
        else if (a == `GMM_A_REL_STBY) raw_rd = meas.rel_stby;
        else if (a == `GMM_A_AGE) raw_rd = age_r;
        else if (a == `GMM_A_SPECIAL) raw_rd = special_r;
        else if (a == `GMM_A_NV_CTRL) raw_rd = nv_ctrl_r;
        else if (in_store) raw_rd = shadow_r[sidx]; // R7
    end

    // Low byte of a pair comes from the hold taken when its MSB was read.
    wire       use_hold = is_pair && a[0];
    wire [7:0] rd_nxt   = use_hold ? hold_lo_r : raw_rd; // R5

    // Read port and the low-byte hold; the hold is retaken on every MSB read.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rdata_r   <= 8'h00;
            rvalid_r  <= 1'b0;
            hold_lo_r <= 8'h00;
        end
        else
        begin
            rvalid_r <= req.rd;
            if (req.rd) rdata_r <= rd_nxt;
            if (req.rd && is_pair && !a[0]) hold_lo_r <= pair_v[7:0]; // R5
            else if (cmd == GMM_CMD_END) hold_lo_r <= raw_rd; // R21
        end
    end

    // Host-writable bytes; read-only locations simply have no write path.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            status_r  <= `GMM_RST_STATUS;
            special_r <= `GMM_RST_SPECIAL;
        end
        else
        begin
            if (req.wr && a == `GMM_A_STATUS) status_r <= req.wdata; // R16 R15 R20
            if (req.wr && a == `GMM_A_SPECIAL) special_r <= req.wdata; // R16
        end
    end

    // Sequencer: copy walks every byte, restore reloads backup at power-up.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            GMM_IDLE:    if (cmd == GMM_CMD_COPY || backup_r) state_nxt = GMM_COPYING;
            GMM_COPYING: if (xfer_r == `GMM_NV_LEN - 6'h01) state_nxt = GMM_IDLE;
            GMM_RESTORE: state_nxt = GMM_IDLE;
            default:     state_nxt = GMM_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= GMM_RESTORE;
            xfer_r  <= 6'h00;
            busy_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            busy_r  <= (state_nxt != GMM_IDLE);
            xfer_r  <= (state_r == GMM_COPYING) ? xfer_r + 6'h01 : 6'h00;
        end
    end

    // Storage control: copy flag, lock enable and sticky lock bits.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            nv_ctrl_r <= 8'h00;
        else
        begin
            nv_ctrl_r[`GMM_BIT_COPY] <= (state_nxt == GMM_COPYING);
            if (req.wr && a == `GMM_A_NV_CTRL && req.wdata[`GMM_BIT_LOCK_EN])
                nv_ctrl_r[`GMM_BIT_LOCK_EN] <= 1'b1; // R16
            else if (cmd != GMM_CMD_NONE && cmd != GMM_CMD_END)
                nv_ctrl_r[`GMM_BIT_LOCK_EN] <= 1'b0;
            // Lock bits only ever set outside reset; reset alone clears them and unlocks a block.
            if (cmd == GMM_CMD_LOCK && nv_ctrl_r[`GMM_BIT_LOCK_EN])
            begin
                nv_ctrl_r[`GMM_BIT_LOCK0] <= 1'b1; // R19
                nv_ctrl_r[`GMM_BIT_LOCK1] <= 1'b1; // R12
            end
        end
    end

    // Coulomb count and age: host writes, engine updates, restore from cells.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            coulomb_r  <= 16'h0000;
            age_r      <= 8'h00;
            last_pct_r <= 8'h00;
            backup_r   <= 1'b0;
        end
        else
        begin
            if (state_r == GMM_RESTORE)
            begin
                coulomb_r <= {cells_r[`GMM_NV_COUL_IDX], cells_r[`GMM_NV_COUL_IDX + 6'h01]}; // R14
                age_r     <= cells_r[`GMM_NV_AGE_IDX];
            end
            else
            begin
                if (coul_hw) coulomb_r[15:8] <= req.wdata; // R16
                else if (coul_lw) coulomb_r[7:0] <= req.wdata;
                else if (coul_upd) coulomb_r <= coul_upd_val;
                if (age_w) age_r <= req.wdata;
                else if (age_upd) age_r <= age_upd_val;
            end
            if (state_r != GMM_RESTORE) last_pct_r <= meas.rel_act;
            if (pct_cross) backup_r <= 1'b1; // R13
            else if (state_r == GMM_COPYING) backup_r <= 1'b0;
        end
    end

    // One generate lane per storage byte: host write, recall, or reset.
    genvar gi;
    generate
        for (gi = 0; gi < 48; gi = gi + 1)
        begin : g_shadow
            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                    shadow_r[gi] <= 8'h00;
                else if (cmd == GMM_CMD_RECALL && !copying)
                    shadow_r[gi] <= cells_r[gi]; // R8
                else if (store_wr && sidx == 6'(gi))
                    shadow_r[gi] <= req.wdata; // R7
            end
        end
    endgenerate

    // Cells keep their contents across reset; they model nonvolatile memory.
    // A copy walks storage bytes then the backup bytes, one per cycle.
    wire [7:0] cell_src = (xfer_r < 6'h30) ? shadow_r[xfer_r] :
                          (xfer_r == `GMM_NV_COUL_IDX) ? coulomb_r[15:8] :
                          (xfer_r == `GMM_NV_COUL_IDX + 6'h01) ? coulomb_r[7:0] : age_r;
    always_ff @(posedge mclk)
    begin
        if (state_r == GMM_COPYING)
            cells_r[xfer_r] <= cell_src; // R8
    end

    // Assertions.
    a_copy_blocks_write: assert property (@(posedge mclk) disable iff (reset)
        copying && req.wr && in_store
        |=> shadow_r[$past(sidx)] == $past(shadow_r[sidx])) // R18
        else $error("storage write landed during copy");
    a_lock_sticky: assert property (@(posedge mclk) disable iff (reset)
        $past(lock0) |-> lock0) // R19
        else $error("block lock cleared");
    a_locked_user_wr: assert property (@(posedge mclk) disable iff (reset)
        lock0 && req.wr && in_user && cmd == GMM_CMD_NONE
        |=> shadow_r[$past(sidx)] == $past(shadow_r[sidx])) // R11
        else $error("locked user block written");
    a_locked_param_wr: assert property (@(posedge mclk) disable iff (reset)
        lock1 && req.wr && in_param && cmd == GMM_CMD_NONE
        |=> shadow_r[$past(sidx)] == $past(shadow_r[sidx])) // R12
        else $error("locked parameter block written");
    // The host leaves one idle cycle between reads, so the pair is read two cycles apart.
    a_low_hold_read: assert property (@(posedge mclk) disable iff (reset)
        req.rd && is_pair && !a[0] ##1 !req.rd && cmd == GMM_CMD_NONE
        ##1 req.rd && a == $past(a, 2) + 8'h01 && cmd == GMM_CMD_NONE
        |=> rdata_r == $past(pair_v[7:0], 3)) // R5
        else $error("low byte not from capture");
    a_ro_discard: assert property (@(posedge mclk) disable iff (reset)
        req.wr && (a == `GMM_A_REL_ACT || a == `GMM_A_FV_TRIM) && cmd == GMM_CMD_NONE
        |=> $stable(status_r) && $stable(special_r) && $stable(nv_ctrl_r[6:0])) // R20
        else $error("read-only write disturbed a register");
    a_lock1_sticky: assert property (@(posedge mclk) disable iff (reset)
        $past(lock1) |-> lock1) // R19
        else $error("parameter block lock cleared");
    a_recall_loads: assert property (@(posedge mclk) disable iff (reset)
        cmd == GMM_CMD_RECALL && !copying |=> shadow_r[0] == $past(cells_r[0])) // R8
        else $error("recall did not load shadow");
    a_status_write: assert property (@(posedge mclk) disable iff (reset)
        req.wr && a == `GMM_A_STATUS |=> status_r == $past(req.wdata)) // R16
        else $error("status write lost");
    a_cross_backup: assert property (@(posedge mclk) disable iff (reset)
        pct_cross |-> ##[1:3] copying) // R13
        else $error("capacity step did not start backup");
    a_copy_len: assert property (@(posedge mclk) disable iff (reset)
        $rose(copying) |-> ##51 !copying) // R8
        else $error("copy length wrong");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
        req.rd && a >= 8'hb2 |=> rdata_r == 8'h00) // R2
        else $error("reserved read nonzero");
endmodule
`default_nettype wire

// ---- dv/gmm_host.sv ----
// Host-side model of the serial front end: byte reads, byte writes, commands.
// Assumes the map samples req and cmd on rising mclk.
`timescale 1ns/1ps
`default_nettype none
module gmm_host
    import gmm_pkg::*;
(
    input  wire logic       mclk,
    output var gmm_req_t    req,
    output var gmm_cmd_t    cmd,
    input  wire logic [7:0] rdata_r,
    input  wire logic       rvalid_r
);
    // The bus is quiet until the bench calls a task.
    initial
    begin
        req = '0;
        cmd = GMM_CMD_NONE;
    end

    // One write pulse; callers never aim it at reserved bytes.
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: dat};
        @(posedge mclk);
        #1;
        req = '0;
    endtask

    // One read pulse; the answer is taken once the sampling edge has landed.
    task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic v);
        @(posedge mclk);
        #1;
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge mclk);
        #1;
        req = '0;
        dat = rdata_r;
        v = rvalid_r;
    endtask

    // Function command pulse, one cycle wide.
    task automatic co(input gmm_cmd_t c);
        @(posedge mclk);
        #1;
        cmd = c;
        @(posedge mclk);
        #1;
        cmd = GMM_CMD_NONE;
    endtask
endmodule
`default_nettype wire

// ---- dv/gauge_memory_map_bench.sv ----
// Self-checking bench for the gauge memory map.
// Assumes gmm_host plays the serial front end and the bench plays the engine.
`timescale 1ns/1ps
`default_nettype none
`include "gmm_defs.svh"
module gauge_memory_map_bench
    import gmm_pkg::*;
;
    logic        mclk;
    logic        reset;
    gmm_req_t    req;
    gmm_cmd_t    cmd;
    logic        active_mode;
    gmm_meas_t   meas;
    logic        coul_upd;
    logic [15:0] coul_upd_val;
    logic        age_upd;
    logic [7:0]  age_upd_val;
    logic [7:0]  rdata_r;
    logic        rvalid_r;
    logic [7:0]  status_r;
    logic [7:0]  special_r;
    logic [15:0] coulomb_r;
    logic [7:0]  age_r;
    logic [7:0]  nv_ctrl_r;
    logic        busy_r;
    int          fails = 0;
    int          samples_checked = 0;

    gmm_map dut_u (.mclk(mclk), .reset(reset), .req(req), .cmd(cmd),
        .active_mode(active_mode), .meas(meas), .coul_upd(coul_upd),
        .coul_upd_val(coul_upd_val), .age_upd(age_upd), .age_upd_val(age_upd_val),
        .rdata_r(rdata_r), .rvalid_r(rvalid_r), .status_r(status_r),
        .special_r(special_r), .coulomb_r(coulomb_r), .age_r(age_r),
        .nv_ctrl_r(nv_ctrl_r), .busy_r(busy_r));
    gmm_host host_u (.mclk(mclk), .req(req), .cmd(cmd), .rdata_r(rdata_r),
        .rvalid_r(rvalid_r));

    // Free-running 125 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // Reads one byte and judges both the valid pulse and the data.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        host_u.rd(a, d, v);
        chk("rvalid_r", 16'h0001, {15'h0000, v});
        chk("rdata_r", {8'h00, e}, {8'h00, d});
    endtask

    // Counts cycles while busy_r stays high; the cap keeps a stuck flag from hanging.
    task automatic busy_len(output int n);
        n = 0;
        while (busy_r === 1'b1 && n < 200)
        begin
            n++;
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic t_pair();
        meas.temp = 16'h1a2b;
        rdc(`GMM_A_TEMP, 8'h1a);
        meas.temp = 16'h3c4d;
        rdc(8'h0b, 8'h2b);
        host_u.co(GMM_CMD_END);
        rdc(`GMM_A_TEMP, 8'h3c);
        rdc(8'h0b, 8'h4d);
        rdc(`GMM_A_FV_TRIM, 8'h9e);
        rdc(8'haf, 8'h8f);
        rdc(`GMM_A_FS_TRIM, 8'h7a);
        rdc(8'hb1, 8'h6b);
        host_u.co(GMM_CMD_END);
        $display("done t_pair");
    endtask

    // Read-only and reserved places, then the writable registers.
    task automatic t_access();
        logic [7:0] rsv [4] = '{8'h1c, 8'h30, 8'h80, 8'hb2};
        host_u.wr(`GMM_A_REL_ACT, 8'hff);
        host_u.wr(`GMM_A_FV_TRIM, 8'h00);
        rdc(`GMM_A_REL_ACT, 8'h04);
        rdc(`GMM_A_FV_TRIM, 8'h9e);
        host_u.co(GMM_CMD_END);
        foreach (rsv[i]) rdc(rsv[i], 8'h00);
        host_u.wr(`GMM_A_STATUS, 8'h5a);
        host_u.wr(`GMM_A_SPECIAL, 8'h00);
        host_u.wr(`GMM_A_COULOMB, 8'h12);
        host_u.wr(8'h11, 8'h34);
        host_u.wr(`GMM_A_AGE, 8'h56);
        chk("status_r", 16'h005a, {8'h00, status_r});
        chk("special_r", 16'h0000, {15'h0000, special_r[0]});
        chk("coulomb_r", 16'h1234, coulomb_r);
        chk("age_r", 16'h0056, {8'h00, age_r});
        $display("done t_access");
    endtask

    // Shadow writes, copy length, writes refused mid-copy, recall.
    task automatic t_store();
        int n;
        host_u.wr(`GMM_USER_LO, 8'ha1);
        host_u.wr(`GMM_PARAM_LO, 8'hc3);
        rdc(`GMM_USER_LO, 8'ha1);
        chk("coulomb_r", 16'h1234, coulomb_r);
        host_u.co(GMM_CMD_COPY);
        chk("nv_ctrl_r", 16'h0001, {15'h0000, nv_ctrl_r[`GMM_BIT_COPY]});
        host_u.wr(`GMM_USER_LO, 8'hee);
        busy_len(n);
        chk("copy_cycles", 16'd49, n[15:0]);
        rdc(`GMM_USER_LO, 8'ha1);
        host_u.wr(`GMM_USER_LO, 8'h33);
        rdc(`GMM_USER_LO, 8'h33);
        host_u.co(GMM_CMD_RECALL);
        busy_len(n);
        rdc(`GMM_USER_LO, 8'ha1);
        rdc(`GMM_PARAM_LO, 8'hc3);
        $display("done t_store");
    endtask

    // Capacity step backup, engine updates, restore after a reset.
    task automatic t_backup();
        int n;
        meas.rel_act = 8'h08;
        repeat (6) @(posedge mclk);
        #1;
        chk("busy_r", 16'h0000, {15'h0000, busy_r});
        active_mode = 1'b1;
        meas.rel_act = 8'h0c;
        n = 0;
        while (busy_r !== 1'b1 && n < 10)
        begin
            n++;
            @(posedge mclk);
            #1;
        end
        chk("busy_r", 16'h0001, {15'h0000, busy_r});
        busy_len(n);
        active_mode = 1'b0;
        coul_upd = 1'b1;
        age_upd = 1'b1;
        @(posedge mclk);
        #1;
        coul_upd = 1'b0;
        age_upd = 1'b0;
        chk("coulomb_r", 16'h9999, coulomb_r);
        chk("age_r", 16'h0011, {8'h00, age_r});
        reset = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk("special_r", 16'h0001, {8'h00, special_r});
        chk("nv_ctrl_r", 16'h0000, {8'h00, nv_ctrl_r});
        reset = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk("coulomb_r", 16'h1234, coulomb_r);
        chk("age_r", 16'h0056, {8'h00, age_r});
        $display("done t_backup");
    endtask

    // Lock both blocks, then try to write and unlock them.
    // Reset cleared the shadow, so the stored bytes are recalled before they are judged.
    task automatic t_lock();
        host_u.co(GMM_CMD_RECALL);
        host_u.wr(`GMM_A_NV_CTRL, 8'h40);
        host_u.co(GMM_CMD_LOCK);
        chk("nv_ctrl_r", 16'h0003, {8'h00, nv_ctrl_r});
        host_u.wr(`GMM_USER_LO, 8'h55);
        host_u.wr(`GMM_PARAM_LO, 8'h55);
        rdc(`GMM_USER_LO, 8'ha1);
        rdc(`GMM_PARAM_LO, 8'hc3);
        host_u.wr(`GMM_A_NV_CTRL, 8'h00);
        host_u.co(GMM_CMD_RECALL);
        chk("nv_ctrl_r", 16'h0003, {8'h00, nv_ctrl_r[1:0]});
        $display("done t_lock");
    endtask

    // Watchdog sized well above the few hundred cycles the tests take.
    initial
    begin
        #50000;
        fails++;
        conclude();
    end

    // Engine-side inputs get values at time zero; then the scenarios run.
    initial
    begin
        reset = 1'b1;
        active_mode = 1'b0;
        meas = '0;
        meas.rel_act = 8'h04;
        meas.fv_trim = 16'h9e8f;
        meas.fs_trim = 16'h7a6b;
        coul_upd = 1'b0;
        coul_upd_val = 16'h9999;
        age_upd = 1'b0;
        age_upd_val = 8'h11;
        repeat (5) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk("special_r", 16'h0001, {8'h00, special_r});
        t_pair();
        t_access();
        t_store();
        t_backup();
        t_lock();
        conclude();
    end
endmodule
`default_nettype wire
